// file: mcs_pkg.sv
// Shared constants and types for the motion CPU status register bank
package mcs_pkg;

  // Register word offsets (byte addresses on APB)
  localparam logic [7:0] OFS_OWN_CPU_NUMBER      = 8'h00;
  localparam logic [7:0] OFS_SERVO_PARAM_AXIS    = 8'h04;
  localparam logic [7:0] OFS_TEST_MODE_LOW       = 8'h08;
  localparam logic [7:0] OFS_TEST_MODE_HIGH      = 8'h0C;
  localparam logic [7:0] OFS_WATCHDOG_CAUSE      = 8'h10;
  localparam logic [7:0] OFS_HANDWHEEL_ERROR     = 8'h14;
  localparam logic [7:0] OFS_PULSE_MAGNIF_LOW    = 8'h18;
  localparam logic [7:0] OFS_PULSE_MAGNIF_HIGH   = 8'h1C;
  localparam logic [7:0] OFS_ACTUAL_CYCLE_TIME   = 8'h20;
  localparam logic [7:0] OFS_ERROR_PROGRAM       = 8'h24;
  localparam logic [7:0] OFS_ERROR_ITEM          = 8'h28;
  localparam logic [7:0] OFS_AMP_LOADED_LOW      = 8'h2C;
  localparam logic [7:0] OFS_AMP_LOADED_HIGH     = 8'h30;
  localparam logic [7:0] OFS_MODE_SWITCH_INFO0   = 8'h34;
  localparam logic [7:0] OFS_MODE_SWITCH_INFO1   = 8'h38;
  localparam logic [7:0] OFS_MODE_SWITCH_INFO2   = 8'h3C;
  localparam logic [7:0] OFS_PEER_LINK_ERROR     = 8'h40;
  localparam logic [7:0] OFS_CYCLE_SETTING_TIME  = 8'h44;
  localparam logic [7:0] OFS_SWITCH_STATE        = 8'h48;
  localparam logic [7:0] OFS_LED_STATE           = 8'h4C;

  // Values after reset
  localparam logic [15:0] RST_WORD               = 16'h0000;
  localparam logic [15:0] RST_SERVO_PARAM_AXIS   = 16'h0001;

  // Field positions in the switch state word
  localparam int unsigned SW_RUNSTOP_LSB         = 0;
  localparam int unsigned SW_MEMCARD_LSB         = 4;
  localparam int unsigned SW_DIP_LSB             = 8;

  // Peer link status codes
  localparam logic [7:0] LINK_NO_ERROR           = 8'h00;
  localparam logic [7:0] LINK_RX_TIMING          = 8'h01;
  localparam logic [7:0] LINK_CRC                = 8'h02;
  localparam logic [7:0] LINK_RESP_CODE          = 8'h03;
  localparam logic [7:0] LINK_RX_FRAME           = 8'h04;
  localparam logic [7:0] LINK_TASK_START         = 8'h05;

  // Run/stop switch position codes
  typedef enum logic [3:0] {
    RS_RUN         = 4'h0,
    RS_STOP        = 4'h1,
    RS_LATCH_CLEAR = 4'h2
  } mcs_runstop_t;

  // Front LED nibble codes
  typedef enum logic [3:0] {
    LED_OFF   = 4'h0,
    LED_ON    = 4'h1,
    LED_FLASH = 4'h2
  } mcs_led_t;

  typedef enum logic [3:0] {
    MODE_OFF    = 4'h0,
    MODE_GREEN  = 4'h1,
    MODE_ORANGE = 4'h2
  } mcs_mode_led_t;

  typedef struct packed {
    mcs_mode_led_t mode;
    mcs_led_t      boot;
    mcs_led_t      battery_alarm_indicator;
    mcs_led_t      motion_run;
    mcs_led_t      error;
    mcs_led_t      run;
  } mcs_led_bank_t;

  typedef struct packed {
    logic [15:0] program_number;
    logic [15:0] item_code;
  } mcs_prog_err_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mcs_apb_req_t;

endpackage : mcs_pkg

// file: mcs_pin_filter.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module mcs_pin_filter
  import mcs_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // At least one pin must pass through
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  // Chain of three flops; only stage2 reads stage1
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts once stage2 and stage3 agree
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= '0;
    end else begin
      for (int b = 0; b < WIDTH; b++) begin
        if (stage2[b] == stage3[b]) begin
          o_level[b] <= stage3[b];
        end
      end
    end
  end

endmodule : mcs_pin_filter

// file: mcs_status_regs.sv
// Motion CPU special status register bank with APB slave
//
// Overview of operation
// - At initial processing store this CPU's number in the multi-CPU system.
// - On test mode request error record per-axis operating bits, two words.
// - On watchdog error store the cause code.
// - On handwheel flag rise store handwheel errors b0-b2, smoothing errors b3-b5.
// - Flag one-pulse magnification setting errors per axis in two words.
// - Every operation cycle update the actual cycle time in microseconds.
// - On servo program error flag rise store the offending program number.
// - On servo program error flag rise store the faulty item code.
// - At initial processing store amplifier presence per axis in two words.
// - Set loaded bit when amplifier appears later; clear it only on reset or a new initial processing.
// - Record three words of real/virtual mode switching error information.
// - Report peer link status as codes 00 to 05.
// - Return peer link code to 00 when normal communication resumes.
// - At initial processing store the configured cycle setting in microseconds.
// - Encode run/stop switch in bits 0-3: 0 run, 1 stop, 2 latch clear.
// - Memory card switch reads off; DIP switches 1-5 at bits 8-12.
// - On LED change update one nibble per LED in fixed order.
// - Mode LED nibble uses 0 off, 1 green, 2 orange.
`timescale 1ns/1ps
module mcs_status_regs
  import mcs_pkg::*;
#(
  parameter int unsigned NUM_AXES = 32
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_rst,
  // APB slave
  input  wire mcs_apb_req_t  i_apb,
  output logic               o_pready,
  output logic               o_pslverr,
  output logic [31:0]        o_prdata,
  // Initial processing
  input  wire logic          i_init_valid,
  input  wire logic [15:0]   i_init_cpu_number,
  input  wire logic [15:0]   i_init_cycle_setting_us,
  input  wire logic [31:0]   i_init_amp_present,
  // Live amplifier presence
  input  wire logic [31:0]   i_amp_present,
  // Error events
  input  wire logic          i_test_mode_err,
  input  wire logic [31:0]   i_axis_operating,
  input  wire logic          i_wdt_err,
  input  wire logic [15:0]   i_wdt_cause,
  input  wire logic          i_handwheel_setting_error_flag,
  input  wire logic [2:0]    i_handwheel_axis_err,
  input  wire logic [2:0]    i_handwheel_smooth_err,
  input  wire logic          i_pulse_magnif_err,
  input  wire logic [31:0]   i_pulse_magnif_axes,
  input  wire logic          i_servo_program_error_flag,
  input  wire mcs_prog_err_t i_servo_prog_err,
  input  wire logic          i_mode_switch_err,
  input  wire logic [47:0]   i_mode_switch_info,
  // Operation cycle
  input  wire logic          i_cycle_tick,
  input  wire logic [15:0]   i_cycle_time_us,
  // Peer link
  input  wire logic          i_link_err,
  input  wire logic [7:0]    i_link_err_code,
  input  wire logic          i_link_ok,
  // Front panel pins and LED status
  input  wire logic [3:0]    i_runstop_pin,
  input  wire logic [4:0]    i_setting_dip_pin,
  input  wire logic          i_led_change,
  input  wire mcs_led_bank_t i_led_bank,
  // Servo parameter read request
  output logic [15:0]        o_servo_param_read_axis,
  output logic               o_servo_param_read_req
);

  // Only the two supported axis counts are served
  if (NUM_AXES != 8 && NUM_AXES != 32) begin : g_bad_axes
    $error("NUM_AXES must be 8 or 32");
  end

  localparam logic [15:0] AXIS_MAX = 16'(NUM_AXES);

  logic [15:0]   own_cpu_number;
  logic [31:0]   test_mode_axes;
  logic [15:0]   watchdog_cause;
  logic [15:0]   handwheel_setting_error;
  logic [31:0]   pulse_magnif_error;
  logic [15:0]   actual_cycle_time;
  mcs_prog_err_t servo_prog_err;
  logic [31:0]   amp_loaded;
  logic [47:0]   mode_switch_error_info;
  logic [15:0]   peer_link_error;
  logic [15:0]   cycle_setting_time;
  logic [15:0]   switch_state;
  logic [15:0]   led_state;
  logic [15:0]   led_ext;
  logic          handwheel_flag_prev;
  logic          servo_flag_prev;
  logic [3:0]    runstop_level;
  logic [4:0]    dip_level;
  logic          wr_fire;
  logic          next_pslverr;
  logic [15:0]   next_rdata;
  logic [15:0]   next_rhigh;
  logic [31:0]   axis_mask;

  assign axis_mask = (NUM_AXES == 32) ? 32'hFFFFFFFF : 32'h000000FF;

  // Switch pins arrive from outside the clock domain
  mcs_pin_filter #(
    .WIDTH (9)
  ) u_pin_filter (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_pin      ({i_setting_dip_pin, i_runstop_pin}),
    .o_level    ({dip_level, runstop_level})
  );

  // Read decode and unmapped-address detection
  always_comb begin
    next_rdata   = RST_WORD;
    next_rhigh   = RST_WORD;
    next_pslverr = 1'b0;
    if (i_apb.paddr[1:0] != 2'b00) begin
      next_pslverr = 1'b1;
    end else begin
      unique case (i_apb.paddr)
        OFS_OWN_CPU_NUMBER:     next_rdata = own_cpu_number;
        OFS_SERVO_PARAM_AXIS:   next_rdata = o_servo_param_read_axis;
        OFS_TEST_MODE_LOW:      next_rdata = test_mode_axes[15:0];
        OFS_TEST_MODE_HIGH:     next_rdata = test_mode_axes[31:16];
        OFS_WATCHDOG_CAUSE:     next_rdata = watchdog_cause;
        OFS_HANDWHEEL_ERROR:    next_rdata = handwheel_setting_error;
        OFS_PULSE_MAGNIF_LOW:   next_rdata = pulse_magnif_error[15:0];
        OFS_PULSE_MAGNIF_HIGH:  next_rdata = pulse_magnif_error[31:16];
        OFS_ACTUAL_CYCLE_TIME:  next_rdata = actual_cycle_time;
        OFS_ERROR_PROGRAM:      next_rdata = servo_prog_err.program_number;
        OFS_ERROR_ITEM:         next_rdata = servo_prog_err.item_code;
        OFS_AMP_LOADED_LOW:     next_rdata = amp_loaded[15:0];
        OFS_AMP_LOADED_HIGH:    next_rdata = amp_loaded[31:16];
        OFS_MODE_SWITCH_INFO0:  next_rdata = mode_switch_error_info[15:0];
        OFS_MODE_SWITCH_INFO1:  next_rdata = mode_switch_error_info[31:16];
        OFS_MODE_SWITCH_INFO2:  next_rdata = mode_switch_error_info[47:32];
        OFS_PEER_LINK_ERROR:    next_rdata = peer_link_error;
        OFS_CYCLE_SETTING_TIME: next_rdata = cycle_setting_time;
        OFS_SWITCH_STATE:       next_rdata = switch_state;
        OFS_LED_STATE: begin
          next_rdata = led_state;
          next_rhigh = led_ext;
        end
        default:                next_pslverr = 1'b1;
      endcase
    end
  end

  // APB answer: one wait-free access phase after each setup cycle
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end else begin
      o_pready  <= i_apb.psel & ~i_apb.penable;
      o_pslverr <= i_apb.psel & ~i_apb.penable & next_pslverr;
      if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
        o_prdata <= {next_rhigh, next_rdata};
      end else begin
        o_prdata <= '0;
      end
    end
  end

  assign wr_fire = i_apb.psel & i_apb.penable & o_pready & i_apb.pwrite & ~o_pslverr;

  // Only the read axis word takes writes; every other word ignores them
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_servo_param_read_axis <= RST_SERVO_PARAM_AXIS;
      o_servo_param_read_req  <= 1'b0;
    end else begin
      o_servo_param_read_req <= 1'b0;
      if (wr_fire && i_apb.paddr == OFS_SERVO_PARAM_AXIS) begin
        if (i_apb.pwdata[15:0] >= 16'h0001 && i_apb.pwdata[15:0] <= AXIS_MAX) begin
          o_servo_param_read_axis <= i_apb.pwdata[15:0];
          o_servo_param_read_req  <= 1'b1;
        end
      end
    end
  end

  // Values caught at initial processing
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      own_cpu_number     <= RST_WORD;
      cycle_setting_time <= RST_WORD;
    end else if (i_init_valid) begin
      own_cpu_number     <= i_init_cpu_number;
      cycle_setting_time <= i_init_cycle_setting_us;
    end
  end

  // Amplifier loading: sticky once seen, until reset or the next initial processing reloads it
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      amp_loaded <= '0;
    end else if (i_init_valid) begin
      amp_loaded <= (i_init_amp_present | i_amp_present) & axis_mask;
    end else begin
      amp_loaded <= (amp_loaded | i_amp_present) & axis_mask;
    end
  end

  // Test mode request error axis bits
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      test_mode_axes <= '0;
    end else if (i_test_mode_err) begin
      test_mode_axes <= i_axis_operating & axis_mask;
    end
  end

  // Watchdog error cause
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      watchdog_cause <= RST_WORD;
    end else if (i_wdt_err) begin
      watchdog_cause <= i_wdt_cause;
    end
  end

  // Handwheel setting errors latched on the flag's rising edge
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      handwheel_flag_prev     <= 1'b0;
      handwheel_setting_error <= RST_WORD;
    end else begin
      handwheel_flag_prev <= i_handwheel_setting_error_flag;
      if (i_handwheel_setting_error_flag && !handwheel_flag_prev) begin
        handwheel_setting_error <= {10'h000, i_handwheel_smooth_err, i_handwheel_axis_err};
      end
    end
  end

  // One-pulse input magnification errors
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_magnif_error <= '0;
    end else if (i_pulse_magnif_err) begin
      pulse_magnif_error <= i_pulse_magnif_axes & axis_mask;
    end
  end

  // Actual operation cycle time
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      actual_cycle_time <= RST_WORD;
    end else if (i_cycle_tick) begin
      actual_cycle_time <= i_cycle_time_us;
    end
  end

  // Servo program error details latched on the flag's rising edge
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      servo_flag_prev <= 1'b0;
      servo_prog_err  <= '0;
    end else begin
      servo_flag_prev <= i_servo_program_error_flag;
      if (i_servo_program_error_flag && !servo_flag_prev) begin
        servo_prog_err.program_number <= i_servo_prog_err.program_number;
        servo_prog_err.item_code      <= i_servo_prog_err.item_code;
      end
    end
  end

  // Real/virtual mode switching error words
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_switch_error_info <= '0;
    end else if (i_mode_switch_err) begin
      mode_switch_error_info <= i_mode_switch_info;
    end
  end

  // Peer link code; a new error wins over a same-cycle recovery
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      peer_link_error <= {8'h00, LINK_NO_ERROR};
    end else if (i_link_err) begin
      peer_link_error <= {8'h00, i_link_err_code};
    end else if (i_link_ok) begin
      peer_link_error <= {8'h00, LINK_NO_ERROR};
    end
  end

  // Switch state word from filtered front pins
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      switch_state <= RST_WORD;
    end else begin
      switch_state                     <= RST_WORD;
      switch_state[SW_RUNSTOP_LSB +: 4] <= runstop_level;
      switch_state[SW_MEMCARD_LSB +: 4] <= 4'h0;
      switch_state[SW_DIP_LSB +: 5]     <= dip_level;
    end
  end

  // LED state word, one nibble per LED
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      led_state <= RST_WORD;
    end else if (i_led_change) begin
      led_state[3:0]   <= i_led_bank.run;
      led_state[7:4]   <= i_led_bank.error;
      led_state[11:8]  <= i_led_bank.motion_run;
      led_state[15:12] <= i_led_bank.battery_alarm_indicator;
    end
  end

  // Boot, two unused and mode nibbles continue the LED word in read data bits 31:16
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      led_ext <= '0;
    end else if (i_led_change) begin
      led_ext[3:0]   <= i_led_bank.boot;
      led_ext[11:4]  <= 8'h00;
      led_ext[15:12] <= i_led_bank.mode;
    end
  end

endmodule : mcs_status_regs

// file: mcs_status_chk.sv
// Bus and axis-request checker for the status register bank
`timescale 1ns/1ps
module mcs_status_chk
  import mcs_pkg::*;
#(
  parameter int unsigned NUM_AXES = 32
) (
  input wire logic         i_core_clk,
  input wire logic         i_rst,
  input wire mcs_apb_req_t i_apb,
  input wire logic         o_pready,
  input wire logic         o_pslverr,
  input wire logic [31:0]  o_prdata,
  input wire logic [15:0]  o_servo_param_read_axis,
  input wire logic         o_servo_param_read_req
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic acc;
  logic bad;
  logic wr_ax;
  logic rd_sw;
  assign acc = i_apb.psel && i_apb.penable && o_pready;
  assign bad = (i_apb.paddr > OFS_LED_STATE) || (i_apb.paddr[1:0] != 2'b00);
  assign wr_ax = acc && i_apb.pwrite && (i_apb.paddr == OFS_SERVO_PARAM_AXIS);
  assign rd_sw = acc && !i_apb.pwrite && (i_apb.paddr == OFS_SWITCH_STATE);
  a_setup_answered: assert property (i_apb.psel && !i_apb.penable |=> o_pready)
    else $error("pready missing after setup");
  a_pready_single: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (o_pready && bad |-> o_pslverr)
    else $error("unmapped access not refused");
  a_mapped_okay: assert property (o_pready && !bad |-> !o_pslverr)
    else $error("mapped access refused");
  a_idle_quiet: assert property (!o_pready |-> (o_prdata == 32'h0) && !o_pslverr)
    else $error("read bus not quiet outside answer");
  a_upper_zero: assert property (o_pready && (i_apb.paddr != OFS_LED_STATE) |-> (o_prdata[31:16] == 16'h0))
    else $error("read data upper half not zero");
  a_led_unused: assert property (o_pready && !i_apb.pwrite && (i_apb.paddr == OFS_LED_STATE) |->
    (o_prdata[27:20] == 8'h00))
    else $error("unused LED nibbles not zero");
  a_axis_take: assert property (wr_ax && (i_apb.pwdata >= 1) && (i_apb.pwdata <= NUM_AXES)
    |=> o_servo_param_read_req && (o_servo_param_read_axis == $past(i_apb.pwdata[15:0])))
    else $error("valid axis write not taken");
  a_axis_refuse: assert property (wr_ax && (i_apb.pwdata[31:16] == 16'h0) &&
    ((i_apb.pwdata == 0) || (i_apb.pwdata > NUM_AXES))
    |=> !o_servo_param_read_req && $stable(o_servo_param_read_axis))
    else $error("out of range axis write taken");
  a_axis_cause: assert property ($changed(o_servo_param_read_axis) |-> $past(wr_ax))
    else $error("axis changed without write");
  a_req_pulse: assert property (o_servo_param_read_req |=> !o_servo_param_read_req)
    else $error("read request longer than one cycle");
  a_switch_fixed: assert property (rd_sw |-> (o_prdata[7:4] == 4'h0) && (o_prdata[15:13] == 3'h0))
    else $error("switch word fixed bits not zero");
  c_axis_write: cover property (wr_ax && o_servo_param_read_req == 1'b0);
  c_unmapped: cover property (o_pready && bad);
  c_switch_read: cover property (rd_sw);
  c_led_read: cover property (o_pready && !i_apb.pwrite && (i_apb.paddr == OFS_LED_STATE));
endmodule : mcs_status_chk

bind mcs_status_regs mcs_status_chk #(.NUM_AXES(NUM_AXES)) u_mcs_status_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_apb(i_apb), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_prdata(o_prdata), .o_servo_param_read_axis(o_servo_param_read_axis),
  .o_servo_param_read_req(o_servo_param_read_req));

// file: mcs_status_regs_test.sv
// Self-checking bench for the status register bank
`timescale 1ns/1ps
module mcs_status_regs_test;
  import mcs_pkg::*;
  logic          clk, rst, pready, pslverr, rq, iv, tme, wde, hwf, pme, spf, mse, tick, le, lok, ledc;
  mcs_apb_req_t  apb;
  mcs_prog_err_t spe;
  mcs_led_bank_t led;
  logic [31:0]   prdata, iamp, amp, aop, pma;
  logic [15:0]   icpu, icyc, wdc, ctu, axis, swv, mhi;
  logic [47:0]   msi;
  logic [7:0]    lec;
  logic [3:0]    rsp;
  logic [4:0]    dip;
  logic [2:0]    hwa, hws;
  logic [23:0]   lv;
  logic [15:0]   m [0:19];
  int            err_total, n_compared;
  int            codes [12] = '{1, 2, 3, 4, 30, 201, 215, 250, 253, 300, 301, 302};

  mcs_status_regs #(.NUM_AXES(32)) u_mcs_status_regs (
    .i_core_clk(clk), .i_rst(rst), .i_apb(apb), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_init_valid(iv), .i_init_cpu_number(icpu), .i_init_cycle_setting_us(icyc),
    .i_init_amp_present(iamp), .i_amp_present(amp), .i_test_mode_err(tme), .i_axis_operating(aop),
    .i_wdt_err(wde), .i_wdt_cause(wdc), .i_handwheel_setting_error_flag(hwf),
    .i_handwheel_axis_err(hwa), .i_handwheel_smooth_err(hws), .i_pulse_magnif_err(pme),
    .i_pulse_magnif_axes(pma), .i_servo_program_error_flag(spf), .i_servo_prog_err(spe),
    .i_mode_switch_err(mse), .i_mode_switch_info(msi), .i_cycle_tick(tick), .i_cycle_time_us(ctu),
    .i_link_err(le), .i_link_err_code(lec), .i_link_ok(lok), .i_runstop_pin(rsp),
    .i_setting_dip_pin(dip), .i_led_change(ledc), .i_led_bank(led),
    .o_servo_param_read_axis(axis), .o_servo_param_read_req(rq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tk;
    @(posedge clk);
  endtask : tk

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic bad(logic [7:0] a);
    return (a > OFS_LED_STATE) || (a[1:0] != 2'b00);
  endfunction : bad

  task automatic mreset;
    foreach (m[i]) m[i] = 16'h0;
    m[1] = RST_SERVO_PARAM_AXIS;
    m[18] = swv;
    mhi = 16'h0;
  endtask : mreset

  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    tk;
    apb <= '{1'b1, 1'b0, w, a, d};
    tk;
    apb.penable <= 1'b1;
    do begin
      tk;
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    apb <= '0;
    if (n >= 50) chk("pready", 32'h1, 32'h0);
  endtask : xfer

  task automatic rd(logic [7:0] a);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk("rd_err", 32'(bad(a)), 32'(e));
    if (!bad(a)) chk($sformatf("reg %h", a), {(a == OFS_LED_STATE) ? mhi : 16'h0, m[a >> 2]}, r);
  endtask : rd

  task automatic rd_all;
    for (int i = 0; i < 20; i++) rd(8'(i * 4));
  endtask : rd_all

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic        e;
    logic        ok;
    ok = (a == OFS_SERVO_PARAM_AXIS) && (d >= 1) && (d <= 32);
    xfer(1'b1, a, d, r, e);
    if (ok) m[1] = d[15:0];
    #1;
    chk("read_req", 32'(ok), 32'(rq));
    chk("axis", 32'(m[1]), 32'(axis));
    chk("wr_err", 32'(bad(a)), 32'(e));
  endtask : wr

  initial begin
    #1000000;
    err_total++;
    wrap_up;
  end

  initial begin
    {iv, tme, wde, hwf, pme, spf, mse, tick, le, lok, ledc} = '0;
    {icpu, icyc, iamp, amp, aop, wdc, hwa, hws, pma, spe, msi, ctu, lec, rsp, dip, led} = '0;
    apb = '0;
    swv = 16'h0;
    rst = 1'b1;
    void'($urandom(32'hF027));
    repeat (10) tk;
    rst <= 1'b0;
    mreset;
    rd_all;
    rd(8'h50);
    rd(8'h02);
    tk;
    iv <= 1'b1;
    icpu <= 16'h0003;
    icyc <= 16'($urandom);
    iamp <= $urandom;
    tk;
    iv <= 1'b0;
    m[0] = icpu;
    m[17] = icyc;
    {m[12], m[11]} = iamp;
    amp <= $urandom;
    tk;
    {m[12], m[11]} = {m[12], m[11]} | amp;
    amp <= 32'h0;
    tk;
    tme <= 1'b1;
    aop <= $urandom;
    pme <= 1'b1;
    pma <= $urandom;
    tick <= 1'b1;
    ctu <= 16'($urandom);
    mse <= 1'b1;
    msi <= 48'({$urandom, $urandom});
    tk;
    {tme, pme, tick, mse} <= '0;
    {m[3], m[2]} = aop;
    {m[7], m[6]} = pma;
    m[8] = ctu;
    {m[15], m[14], m[13]} = msi;
    hwf <= 1'b1;
    {hwa, hws} <= 6'($urandom);
    spf <= 1'b1;
    spe <= mcs_prog_err_t'($urandom);
    tk;
    m[5] = {10'h0, hws, hwa};
    m[9] = spe.program_number;
    m[10] = spe.item_code;
    {hwa, hws} <= ~{hwa, hws};
    spe <= ~spe;
    tk;
    hwf <= 1'b0;
    spf <= 1'b0;
    rd_all;
    foreach (codes[k]) begin
      wde <= 1'b1;
      wdc <= 16'(codes[k]);
      tk;
      wde <= 1'b0;
      m[4] = wdc;
      rd(OFS_WATCHDOG_CAUSE);
    end
    for (int k = 1; k <= 5; k++) begin
      le <= 1'b1;
      lec <= 8'(k);
      lok <= (k == 5);
      tk;
      {le, lok} <= '0;
      m[16] = 16'(k);
      rd(OFS_PEER_LINK_ERROR);
      lok <= 1'b1;
      tk;
      lok <= 1'b0;
      m[16] = 16'h0;
      rd(OFS_PEER_LINK_ERROR);
    end
    for (int k = 0; k < 3; k++) begin
      rsp <= 4'(k);
      dip <= 5'($urandom);
      for (int j = 0; j < 6; j++) lv[j * 4 +: 4] = 4'($urandom % 3);
      led <= mcs_led_bank_t'(lv);
      ledc <= 1'b1;
      tk;
      ledc <= 1'b0;
      repeat (8) tk;
      swv = {3'h0, dip, 4'h0, rsp};
      m[18] = swv;
      m[19] = lv[15:0];
      mhi = {lv[23:20], 8'h00, lv[19:16]};
      rd(OFS_SWITCH_STATE);
      rd(OFS_LED_STATE);
    end
    for (int i = 0; i < 20; i++) if (i != 1) wr(8'(i * 4), $urandom);
    wr(8'h50, 32'h1);
    wr(OFS_SERVO_PARAM_AXIS, 32'd32);
    wr(OFS_SERVO_PARAM_AXIS, 32'd0);
    wr(OFS_SERVO_PARAM_AXIS, 32'd33);
    wr(OFS_SERVO_PARAM_AXIS, 32'd1);
    rd_all;
    tk;
    rst <= 1'b1;
    repeat (2) tk;
    rst <= 1'b0;
    mreset;
    rd_all;
    wrap_up;
  end
endmodule : mcs_status_regs_test
